/* File: verilog/fcl_pkg.sv */
// Package for the flash configuration, latency and layout-lock block.
// Assumes a 32-bit classic Wishbone register bus and a single-line link.
package fcl_pkg;

  // Register byte offsets.
  localparam logic [4:0] FCL_OFS_LAYOUT = 5'h00;
  localparam logic [4:0] FCL_OFS_LAT_NV = 5'h04;
  localparam logic [4:0] FCL_OFS_LAT_V = 5'h08;
  localparam logic [4:0] FCL_OFS_STATUS = 5'h0C;
  localparam logic [4:0] FCL_OFS_LONG_OPC = 5'h10;

  // Field positions of the layout and lock register.
  localparam int FCL_B_TEMP_LOCK = 0;
  localparam int FCL_B_TOP_SEL = 2;
  localparam int FCL_B_PERM_LOCK = 4;
  localparam int FCL_B_PROT_TOP = 5;
  localparam int FCL_B_SPLIT = 6;
  localparam int FCL_B_BP_LO = 8;
  localparam int FCL_BP_W = 3;

  // Field positions of the latency and address register.
  localparam int FCL_B_ADDR_LEN = 7;
  localparam int FCL_LAT_W = 4;

  // Field positions of the status register.
  localparam int FCL_B_ST_LAYOUT = 0;
  localparam int FCL_B_ST_ADDR4 = 2;
  localparam int FCL_B_ST_DUMMY = 8;

  // Reset values.
  localparam logic [7:0] FCL_LAT_RESET = 8'h08;
  localparam logic [7:0] FCL_LONG_OPC_RESET = 8'h00;

  // Sector layout codes.
  localparam logic [1:0] FCL_LAYOUT_BOTTOM = 2'h0;
  localparam logic [1:0] FCL_LAYOUT_TOP = 2'h1;
  localparam logic [1:0] FCL_LAYOUT_SPLIT = 2'h2;

  // Link framing.
  localparam logic [5:0] FCL_OPC_BITS = 6'h08;
  localparam logic [5:0] FCL_ADDR3_BITS = 6'h18;
  localparam logic [5:0] FCL_ADDR4_BITS = 6'h20;

  // Long dummy count per latency code; the short count equals the code.
  localparam logic [15:0][4:0] FCL_LONG_LAT = {
    5'h1C, 5'h1B, 5'h1A, 5'h19, 5'h18, 5'h17, 5'h16, 5'h14,
    5'h12, 5'h10, 5'h0E, 5'h0C, 5'h0A, 5'h08, 5'h06, 5'h05};

  typedef enum logic [2:0] {
    FCL_IDLE,
    FCL_OPC,
    FCL_ADDR,
    FCL_DUMMY,
    FCL_DATA
  } fcl_link_st_t;

endpackage

/* File: verilog/fcl_sync.sv */
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level or a clock far below sys_clk.
`timescale 1ns/1ps
`default_nettype none
module fcl_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/fcl_lat_dec.sv */
// Dummy-cycle decoder from the four-bit latency code.
// Assumes the caller says whether the opcode takes the long count.
`timescale 1ns/1ps
`default_nettype none
module fcl_lat_dec (
  // Selection
  input wire logic [fcl_pkg::FCL_LAT_W-1:0] code,
  input wire logic long_sel,
  // Result
  output logic [4:0] dummy
);

  always_comb begin
    if (long_sel) begin
      dummy = fcl_pkg::FCL_LONG_LAT[code];
    end else begin
      dummy = {1'b0, code};
    end
  end

endmodule
`default_nettype wire

/* File: verilog/fcl_top.sv */
// Configuration block: sector layout, layout locks, latency and address.
// Assumes a classic Wishbone master on sys_clk and a slow link clock.
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fcl_top #(
  parameter int ADR_W = 5
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial link
  input wire logic link_sck,
  input wire logic link_cs_n,
  input wire logic link_si,
  // Status
  output logic [1:0] sector_layout,
  output logic addr_len_sel,
  output logic layout_locked,
  output logic data_phase
);

  // Widths of the decoded address and of the register fields.
  localparam int ADR_DEC_W = 5;
  localparam int REG_W = 8;
  localparam int DUMMY_W = 5;
  localparam int LAYOUT_W = 2;

  // The five decoded address bits must exist on the bus.
  if (ADR_W < ADR_DEC_W) begin : g_adr_check
    $error("fcl_top: ADR_W must be at least 5");
  end

  typedef struct packed {
    // Register bus answer.
    logic ack;
    logic [31:0] rdata;
    // Layout and lock bits.
    logic temporary_layout_lock;
    logic permanent_layout_lock;
    logic param_sector_top_sel;
    logic param_sector_split;
    logic protect_from_top;
    logic [fcl_pkg::FCL_BP_W-1:0] block_protect_field;
    logic lock_any;
    // Latency and address configuration.
    logic [REG_W-1:0] lat_nv;
    logic [REG_W-1:0] lat_v;
    logic lat_load;
    logic [REG_W-1:0] long_opc;
    // Link framing and the registered sector layout.
    logic sck_d;
    fcl_pkg::fcl_link_st_t st;
    logic [5:0] cnt;
    logic [7:0] shift;
    logic [DUMMY_W-1:0] dummy;
    logic [DUMMY_W-1:0] last_dummy;
    logic data_phase;
    logic [LAYOUT_W-1:0] layout;
  } fcl_state_t;

  fcl_state_t q_reg;
  fcl_state_t q_next;
  logic [2:0] link_sync;
  logic sck_s;
  logic cs_n_s;
  logic si_s;
  logic long_sel;
  logic [4:0] lat_dummy;
  logic [7:0] opc_now;

  fcl_sync #(
    .WIDTH(3)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    // Chip select goes in inverted, so that the reset value of the
    // synchroniser reads as deselected and no false frame follows reset.
    .async_in({link_sck, ~link_cs_n, link_si}),
    .sync_out(link_sync)
  );

  assign sck_s = link_sync[2];
  assign cs_n_s = !link_sync[1];
  assign si_s = link_sync[0];
  assign opc_now = {q_reg.shift[6:0], si_s};
  assign long_sel = (opc_now == q_reg.long_opc);

  fcl_lat_dec u_lat (
    .code(q_reg.lat_v[fcl_pkg::FCL_LAT_W-1:0]),
    .long_sel(long_sel),
    .dummy(lat_dummy)
  );

  always_comb begin
    logic req;
    logic wr;
    logic locked;
    logic sck_rise;
    logic [ADR_DEC_W-1:0] adr;
    logic [5:0] addr_bits;
    q_next = q_reg;
    // Ack masks the request, so a held strobe is not answered twice in a row.
    req = wb_cyc_i && wb_stb_i && !q_reg.ack;
    wr = req && wb_we_i;
    adr = wb_adr_i[ADR_DEC_W-1:0];
    locked = q_reg.permanent_layout_lock || q_reg.temporary_layout_lock;
    sck_rise = sck_s && !q_reg.sck_d;
    addr_bits = q_reg.lat_v[fcl_pkg::FCL_B_ADDR_LEN] ?
      fcl_pkg::FCL_ADDR4_BITS : fcl_pkg::FCL_ADDR3_BITS;

    // One-cycle answer; ack falls in the cycle after it rose.
    q_next.ack = req;
    q_next.rdata = '0;

    // The copy runs one cycle after reset, since the async reset only
    // loads constants.
    if (q_reg.lat_load) begin
      q_next.lat_v = q_reg.lat_nv;
      q_next.lat_load = 1'b0;
    end

    if (wr && adr == fcl_pkg::FCL_OFS_LAYOUT) begin
      if (wb_sel_i[0]) begin
        // The lock that stands before the write decides, so a write that
        // sets a lock may still move the layout once.
        if (!locked) begin
          q_next.param_sector_top_sel = wb_dat_i[fcl_pkg::FCL_B_TOP_SEL];
          q_next.param_sector_split = wb_dat_i[fcl_pkg::FCL_B_SPLIT];
          q_next.protect_from_top = wb_dat_i[fcl_pkg::FCL_B_PROT_TOP];
        end
        if (wb_dat_i[fcl_pkg::FCL_B_PERM_LOCK]) begin
          q_next.permanent_layout_lock = 1'b1;
        end
        if (wb_dat_i[fcl_pkg::FCL_B_TEMP_LOCK]) begin
          q_next.temporary_layout_lock = 1'b1;
        end
      end
      if (wb_sel_i[1] && !locked) begin
        q_next.block_protect_field = wb_dat_i[fcl_pkg::FCL_B_BP_LO +:
          fcl_pkg::FCL_BP_W];
      end
    end

    // Kept as a flop of its own so that the pin comes straight from it.
    q_next.lock_any = q_next.permanent_layout_lock ||
      q_next.temporary_layout_lock;
    if (wr && wb_sel_i[0]) begin
      // Reserved bits are stored as written; keeping them zero is the
      // host's duty.
      if (adr == fcl_pkg::FCL_OFS_LAT_NV) begin
        q_next.lat_nv = wb_dat_i[REG_W-1:0];
      end
      if (adr == fcl_pkg::FCL_OFS_LAT_V) begin
        q_next.lat_v = wb_dat_i[REG_W-1:0];
        q_next.lat_load = 1'b0;
      end
      if (adr == fcl_pkg::FCL_OFS_LONG_OPC) begin
        q_next.long_opc = wb_dat_i[REG_W-1:0];
      end
    end

    // Read data stands for the ack cycle only and is zero otherwise.
    if (req && !wb_we_i) begin
      case (adr)
        fcl_pkg::FCL_OFS_LAYOUT: begin
          q_next.rdata[fcl_pkg::FCL_B_TEMP_LOCK] =
            q_reg.temporary_layout_lock;
          q_next.rdata[fcl_pkg::FCL_B_TOP_SEL] = q_reg.param_sector_top_sel;
          q_next.rdata[fcl_pkg::FCL_B_PERM_LOCK] =
            q_reg.permanent_layout_lock;
          q_next.rdata[fcl_pkg::FCL_B_PROT_TOP] = q_reg.protect_from_top;
          q_next.rdata[fcl_pkg::FCL_B_SPLIT] = q_reg.param_sector_split;
          q_next.rdata[fcl_pkg::FCL_B_BP_LO +: fcl_pkg::FCL_BP_W] =
            q_reg.block_protect_field;
        end
        fcl_pkg::FCL_OFS_LAT_NV: begin
          q_next.rdata[REG_W-1:0] = q_reg.lat_nv;
        end
        fcl_pkg::FCL_OFS_LAT_V: begin
          q_next.rdata[REG_W-1:0] = q_reg.lat_v;
        end
        fcl_pkg::FCL_OFS_STATUS: begin
          q_next.rdata[fcl_pkg::FCL_B_ST_LAYOUT +: LAYOUT_W] = q_reg.layout;
          q_next.rdata[fcl_pkg::FCL_B_ST_ADDR4] =
            q_reg.lat_v[fcl_pkg::FCL_B_ADDR_LEN];
          q_next.rdata[fcl_pkg::FCL_B_ST_DUMMY +: DUMMY_W] = q_reg.last_dummy;
        end
        fcl_pkg::FCL_OFS_LONG_OPC: begin
          q_next.rdata[REG_W-1:0] = q_reg.long_opc;
        end
        default: begin
          q_next.rdata = '0;
        end
      endcase
    end

    // Sector layout decode.
    // Registered, so the layout pins trail the configuration bits by a cycle.
    if (q_reg.param_sector_split) begin
      q_next.layout = fcl_pkg::FCL_LAYOUT_SPLIT;
    end else if (q_reg.param_sector_top_sel) begin
      q_next.layout = fcl_pkg::FCL_LAYOUT_TOP;
    end else begin
      q_next.layout = fcl_pkg::FCL_LAYOUT_BOTTOM;
    end

    // Link framing: opcode, address bytes, dummy cycles, then data.
    q_next.sck_d = sck_s;
    if (cs_n_s) begin
      q_next.st = fcl_pkg::FCL_OPC;
      q_next.cnt = '0;
      q_next.data_phase = 1'b0;
    end else if (sck_rise) begin
      q_next.cnt = q_reg.cnt + 6'h01;
      case (q_reg.st)
        fcl_pkg::FCL_OPC: begin
          q_next.shift = opc_now;
          if (q_reg.cnt + 6'h01 == fcl_pkg::FCL_OPC_BITS) begin
            // The count is latched here and reported in status.
            q_next.dummy = lat_dummy;
            q_next.last_dummy = lat_dummy;
            q_next.st = fcl_pkg::FCL_ADDR;
            q_next.cnt = '0;
          end
        end
        fcl_pkg::FCL_ADDR: begin
          if (q_reg.cnt + 6'h01 == addr_bits) begin
            q_next.cnt = '0;
            if (q_reg.dummy == 5'h00) begin
              q_next.st = fcl_pkg::FCL_DATA;
              q_next.data_phase = 1'b1;
            end else begin
              q_next.st = fcl_pkg::FCL_DUMMY;
            end
          end
        end
        fcl_pkg::FCL_DUMMY: begin
          if (q_reg.cnt + 6'h01 == {1'b0, q_reg.dummy}) begin
            q_next.st = fcl_pkg::FCL_DATA;
            q_next.data_phase = 1'b1;
          end
        end
        fcl_pkg::FCL_DATA: begin
          q_next.cnt = '0;
        end
        fcl_pkg::FCL_IDLE: begin
          q_next.st = fcl_pkg::FCL_OPC;
          q_next.cnt = '0;
        end
        default: begin
          q_next.st = fcl_pkg::FCL_OPC;
          q_next.cnt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q_reg <= '0;
      q_reg.lat_nv <= fcl_pkg::FCL_LAT_RESET;
      q_reg.lat_v <= fcl_pkg::FCL_LAT_RESET;
      q_reg.lat_load <= 1'b1;
      q_reg.long_opc <= fcl_pkg::FCL_LONG_OPC_RESET;
      q_reg.st <= fcl_pkg::FCL_IDLE;
      q_reg.layout <= fcl_pkg::FCL_LAYOUT_BOTTOM;
    end else begin
      q_reg <= q_next;
    end
  end

  assign wb_ack_o = q_reg.ack;
  assign wb_dat_o = q_reg.rdata;
  assign sector_layout = q_reg.layout;
  assign addr_len_sel = q_reg.lat_v[fcl_pkg::FCL_B_ADDR_LEN];
  assign layout_locked = q_reg.lock_any;
  assign data_phase = q_reg.data_phase;

endmodule
`default_nettype wire

/* File: verification/fcl_chk.sv */
// Port-level assertions for the configuration block.
// Assumes one sys_clk domain and a bind onto fcl_top.
`timescale 1ns/1ps
`default_nettype none
module fcl_chk #(
  parameter int ADR_W = 5
) (
  // Clock, reset and Wishbone
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Link and status
  input wire logic link_sck,
  input wire logic link_cs_n,
  input wire logic link_si,
  input wire logic [1:0] sector_layout,
  input wire logic addr_len_sel,
  input wire logic layout_locked,
  input wire logic data_phase
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // A write is taken while acknowledge is still low.
  sequence wr_take;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  endsequence
  sequence lay_wr;
    wr_take ##0 (wb_adr_i == 5'h00 && !layout_locked);
  endsequence
  sequence lat_wr;
    wr_take ##0 wb_adr_i == 5'h08;
  endsequence
  layout_bottom_a:
    assert property (lay_wr ##0 (!wb_dat_i[6] && !wb_dat_i[2]) |=>
      ##[0:1] sector_layout == 2'h0) else $error("layout not bottom");
  layout_top_a:
    assert property (lay_wr ##0 (!wb_dat_i[6] && wb_dat_i[2]) |=>
      ##[0:1] sector_layout == 2'h1) else $error("layout not top");
  layout_split_a:
    assert property (lay_wr ##0 wb_dat_i[6] |=>
      ##[0:1] sector_layout == 2'h2) else $error("layout not split");
  lock_sticky_a:
    assert property (layout_locked |=> layout_locked)
      else $error("lock dropped");
  // The write that sets a lock may still move the layout one cycle later.
  lock_freeze_a:
    assert property (layout_locked && $past(layout_locked) |=>
      $stable(sector_layout)) else $error("locked layout changed");
  lock_cause_a:
    assert property (!layout_locked && !(wb_cyc_i && wb_we_i) |=>
      !layout_locked) else $error("lock set without a write");
  addr_four_a:
    assert property (lat_wr ##0 wb_dat_i[7] |=> ##[0:1] addr_len_sel)
      else $error("four address bytes not selected");
  addr_three_a:
    assert property (lat_wr ##0 !wb_dat_i[7] |=> ##[0:1] !addr_len_sel)
      else $error("three address bytes not selected");
  data_idle_a:
    assert property (link_cs_n [*6] |-> !data_phase)
      else $error("data phase outside a frame");
endmodule
bind fcl_top fcl_chk #(.ADR_W(ADR_W)) chk_u (.sys_clk, .rst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .link_sck, .link_cs_n, .link_si, .sector_layout, .addr_len_sel,
  .layout_locked, .data_phase);
`default_nettype wire

/* File: verification/fcl_host.sv */
// Host link model: opcode, address bits and dummy clocks per frame.
// Assumes the bench raises go once per frame and waits for busy to drop.
`timescale 1ns/1ps
`default_nettype none
module fcl_host (
  // Frame request
  input wire logic go,
  input wire logic [7:0] opc,
  input wire logic addr4,
  input wire logic [4:0] n_dum,
  // Progress
  output logic busy,
  output logic tail,
  // Link pins
  output logic sck,
  output logic cs_n,
  output logic si
);
  int nb;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    busy = 1'b0;
    tail = 1'b0;
  end
  // The clock stands low between frames, so stray edges would be a fault.
  always @(posedge go) begin
    busy = 1'b1;
    cs_n = 1'b0;
    nb = 8 + (addr4 ? 32 : 24) + n_dum;
    for (int i = 0; i < nb; i++) begin
      si = (i < 8) ? opc[7-i] : ~si;
      tail = (i == nb - 1);
      #32 sck = 1'b1;
      #32 sck = 1'b0;
    end
    tail = 1'b0;
    #200 cs_n = 1'b1;
    si = ~si;
    #100 busy = 1'b0;
  end
endmodule
`default_nettype wire

/* File: verification/flash_config_latency_addr_lock_test.sv */
// Bench for the configuration block: register access and link frames.
// Assumes fcl_top, its checker bind and the fcl_host link model.
`timescale 1ns/1ps
`default_nettype none
module flash_config_latency_addr_lock_test;
  logic sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [4:0] wb_adr_i, n_dum;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic link_sck, link_cs_n, link_si, addr_len_sel, layout_locked;
  logic data_phase, go, addr4, busy, tail;
  logic [1:0] sector_layout;
  logic [7:0] opc;
  logic [31:0] lay [4] = '{32'h04, 32'h40, 32'h44, 32'h00};
  logic [31:0] lay_exp [4] = '{32'h1, 32'h2, 32'h2, 32'h0};
  int n_fail = 0;
  int cmp_count = 0;
  fcl_top #(.ADR_W(5)) dut_u (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .link_sck,
    .link_cs_n, .link_si, .sector_layout, .addr_len_sel, .layout_locked,
    .data_phase);
  fcl_host host_u (.go, .opc, .addr4, .n_dum, .busy, .tail, .sck(link_sck),
    .cs_n(link_cs_n), .si(link_si));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d, input logic [3:0] s);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    cmp(q, e);
  endtask
  task automatic frame(input logic [7:0] o, input logic a4,
    input logic [4:0] n);
    @(posedge sys_clk);
    opc <= o;
    addr4 <= a4;
    n_dum <= n;
    go <= 1'b1;
    @(posedge tail);
    @(posedge sys_clk) go <= 1'b0;
    repeat (3) @(negedge sys_clk);
    cmp({31'h0, data_phase}, 32'h0);
    @(negedge tail);
    repeat (12) @(negedge sys_clk);
    cmp({31'h0, data_phase}, 32'h1);
    wait (!busy);
    rd(5'h0C, {19'h0, n, 5'h0, a4, 2'h0});
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    close_out;
  end
  initial begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, go, addr4} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, opc, n_dum} = '0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(5'h04, 32'h08);
    rd(5'h08, 32'h08);
    rd(5'h14, 32'h00);
    $display("reset values done");
    frame(8'h0B, 1'b0, 5'd8);
    bus(1'b1, 5'h10, 32'hEE, 4'h1);
    bus(1'b1, 5'h08, 32'h8F, 4'h1);
    @(negedge sys_clk);
    cmp({31'h0, addr_len_sel}, 32'h1);
    frame(8'hEE, 1'b1, 5'd28);
    frame(8'h0B, 1'b1, 5'd15);
    bus(1'b1, 5'h08, 32'h00, 4'h0);
    rd(5'h08, 32'h8F);
    bus(1'b1, 5'h08, 32'h00, 4'h1);
    frame(8'hEE, 1'b0, 5'd5);
    frame(8'h0B, 1'b0, 5'd0);
    $display("link frames done");
    foreach (lay[i]) begin
      bus(1'b1, 5'h00, lay[i], 4'h1);
      @(negedge sys_clk);
      cmp({30'h0, sector_layout}, lay_exp[i]);
    end
    bus(1'b1, 5'h00, 32'h01, 4'h1);
    bus(1'b1, 5'h00, 32'h744, 4'h3);
    bus(1'b1, 5'h08, 32'h80, 4'h1);
    @(negedge sys_clk);
    cmp({30'h0, sector_layout}, 32'h0);
    rd(5'h00, 32'h01);
    cmp({31'h0, layout_locked}, 32'h1);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd(5'h00, 32'h00);
    cmp({31'h0, layout_locked}, 32'h0);
    rd(5'h08, 32'h08);
    bus(1'b1, 5'h00, 32'h10, 4'h1);
    bus(1'b1, 5'h00, 32'h144, 4'h3);
    bus(1'b1, 5'h00, 32'h00, 4'h1);
    rd(5'h00, 32'h10);
    cmp({31'h0, layout_locked}, 32'h1);
    $display("layout and lock tests done");
    close_out;
  end
endmodule
`default_nettype wire
